// file: rtl/dma_engine.sv
// four-channel dma engine: registers, arbitration, bus sequencing
// Operation
// RULE1: software uses word or long accesses, except operation and channel control registers.
// RULE2: clear channel enable before changing the request source select field.
// RULE3: nmi sets the nmi stop flag even when no channel is active.
// RULE4: nmi during a transfer halts the engine and releases the bus.
// RULE5: burst mode keeps the bus until the transfer completes.
// RULE6: cycle-steal mode releases the bus after every transfer unit.
// RULE7: software keeps the overlapped-access setting of the bus controller cleared.
// RULE8: software stops dma before sleep and restarts it only after wake-up.
// RULE9: software waiting for completion polls the transfer end flag, not sleep.
// RULE10: level requests in cycle steal are resampled early in the next unit.
// RULE11: acknowledge late in the cycle lets a held request cause an extra unit.
// RULE12: external requesters use edges and raise the next after acknowledge.
// RULE13: switching a low pin to request function with edge detection requests at once.
// RULE14: software switches the pin to request function only while it is high.
// RULE15: operation value 0x0001 enables all channels, fixed priority 0, 3, 2, 1.
// RULE16: channel control 0x1805 selects fixed dst, inc src, timer0, steal, byte, ie, de.
// RULE17: channel control 0x4405 selects inc dst, fixed src, serial0 rx, steal, byte, ie, de.
// RULE18: transfer count holds the unit count directly.
// RULE19: count reaching zero sets transfer end and, if enabled, the end interrupt.
// RULE20: nmi or address error stops all channels without transfer end flags.
`timescale 1ns/1ps
`default_nettype none
module dma_engine #(
  parameter int NCH = dma_pkg::NCH,
  parameter int MDW = dma_pkg::MDW
) (
  // clock, reset, enable
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  // register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  // events and request sources
  input  wire logic             nmi_i,
  input  wire logic [NCH-1:0]   xfer_req_n_i,
  input  wire logic [NCH-1:0]   req_pin_sel_i,
  input  wire logic [15:0]      periph_req_i,
  // system bus
  output logic                  bus_req_o,
  input  wire logic             bus_grant_i,
  output logic      [31:0]      mem_addr_o,
  output logic                  mem_rd_o,
  output logic                  mem_wr_o,
  output logic                  mem_word_o,
  output logic      [MDW-1:0]   mem_wdata_o,
  input  wire logic [MDW-1:0]   mem_rdata_i,
  input  wire logic             mem_ready_i,
  // handshake and completion
  output logic      [NCH-1:0]   xfer_ack_o,
  output logic      [NCH-1:0]   end_irq_o
);

  // priority table and address decode assume exactly four channels
  if (NCH != 4 || MDW != 16) begin : g_chk
    $error("dma_engine supports four channels and a 16-bit bus only");
  end

  logic [31:0]     sar_r  [NCH];
  logic [31:0]     dar_r  [NCH];
  logic [15:0]     tcr_r  [NCH];
  logic [15:0]     channel_control_register_r [NCH];
  logic [15:0]     opr_r;
  dma_pkg::st_e    state_r;
  logic [1:0]      cur_r;
  logic            rd_first_r;
  logic [NCH-1:0]  elig;
  logic [NCH-1:0]  te_set;
  logic [2:0]      win;
  logic            stop;
  logic            done;
  logic            mis;
  logic            ae_set;
  logic            grant_ok;
  logic            cur_word;
  logic            cur_burst;
  logic            last_unit;
  logic [31:0]     rd_val;

  dma_req_if #(.NCH(NCH)) rq ();

  dma_req_sampler #(.NCH(NCH)) u_smp (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .rq        (rq)
  );

  // channel register hit, aligned to four bytes
  function automatic logic ch_hit(input logic [7:0] a);
    ch_hit = (a < dma_pkg::CH_SPAN) && (a[1:0] == 2'b00);
  endfunction : ch_hit

  // next address for fixed, increment or decrement
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m, input logic w);
    logic [31:0] d;
    d = w ? 32'h0000_0002 : 32'h0000_0001;
    case (m)
      dma_pkg::AM_INC: step = a + d;
      dma_pkg::AM_DEC: step = a - d;
      default:         step = a;
    endcase
  endfunction : step

  // highest eligible channel in table order; bit 2 marks a hit
  function automatic logic [2:0] pick(input logic [NCH-1:0] e);
    pick = 3'b000;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (e[dma_pkg::PRIO[i]]) begin
        pick = {1'b1, dma_pkg::PRIO[i]};
      end
    end
  endfunction : pick

  // global stop: nmi acts in its own cycle, flags hold it afterwards
  assign stop = ~opr_r[dma_pkg::B_DME] | opr_r[dma_pkg::B_NMI_STOP_FLAG]
              | opr_r[dma_pkg::B_AE] | nmi_i; // RULE4 RULE20
  assign win = pick(elig); // RULE15
  assign cur_word  = channel_control_register_r[cur_r][dma_pkg::B_TS];
  assign cur_burst = channel_control_register_r[cur_r][dma_pkg::B_TM];
  assign mis  = cur_word & (sar_r[cur_r][0] | dar_r[cur_r][0]);
  assign grant_ok = (state_r == dma_pkg::ST_REQ) && bus_grant_i && !stop
                 && channel_control_register_r[cur_r][dma_pkg::B_DE];
  assign ae_set = grant_ok && mis; // RULE20
  assign done = (state_r == dma_pkg::ST_WR) && mem_ready_i;
  assign last_unit = (tcr_r[cur_r] == 16'h0001);

  assign rq.ce = ce_i;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [3:0] rs;
    logic       wsel;
    assign rs   = channel_control_register_r[c][dma_pkg::RS_LSB +: 4];
    assign wsel = reg_wr_i && ch_hit(reg_addr_i) && (reg_addr_i[5:4] == 2'(c));
    assign te_set[c] = done && (cur_r == 2'(c)) && last_unit; // RULE19

    // pin reads high while it is still a general input
    assign rq.lvl_n[c] = (rs == dma_pkg::RS_PIN)
                       ? (req_pin_sel_i[c] ? xfer_req_n_i[c] : 1'b1)
                       : ~periph_req_i[rs]; // RULE13
    assign rq.edge_mode[c] = channel_control_register_r[c][dma_pkg::B_DS];
    // idle channels sample every cycle; the active one early in its read
    assign rq.samp[c] = (state_r == dma_pkg::ST_IDLE) || (cur_r != 2'(c))
                      || ((state_r == dma_pkg::ST_RD) && rd_first_r); // RULE10 RULE11
    assign rq.taken[c] = grant_ok && !mis && (cur_r == 2'(c));
    assign elig[c] = channel_control_register_r[c][dma_pkg::B_DE] && !channel_control_register_r[c][dma_pkg::B_TE]
                   && (tcr_r[c] != 16'h0000) && rq.pend[c] && !stop;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sar_r[c] <= dma_pkg::ADR_RST;
        dar_r[c] <= dma_pkg::ADR_RST;
        tcr_r[c] <= dma_pkg::TCR_RST;
      end else if (ce_i) begin
        if (done && cur_r == 2'(c)) begin
          // a unit just landed; its update beats a same-cycle write
          sar_r[c] <= step(sar_r[c], channel_control_register_r[c][dma_pkg::SM_LSB +: 2], channel_control_register_r[c][dma_pkg::B_TS]);
          dar_r[c] <= step(dar_r[c], channel_control_register_r[c][dma_pkg::DM_LSB +: 2], channel_control_register_r[c][dma_pkg::B_TS]);
          tcr_r[c] <= 16'(tcr_r[c] - 16'h0001); // RULE18
        end else if (wsel) begin
          case (reg_addr_i[3:0])
            dma_pkg::OFF_SAR: sar_r[c] <= reg_wdata_i;
            dma_pkg::OFF_DAR: dar_r[c] <= reg_wdata_i;
            dma_pkg::OFF_TCR: tcr_r[c] <= reg_wdata_i[15:0]; // RULE18
            default: ;
          endcase
        end
      end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        channel_control_register_r[c] <= dma_pkg::CHANNEL_CONTROL_REGISTER_RST;
      end else if (ce_i) begin
        if (wsel && reg_addr_i[3:0] == dma_pkg::OFF_CHANNEL_CONTROL_REGISTER) begin
          // whole field layout decodes 0x1805 and 0x4405 as written
          channel_control_register_r[c] <= reg_wdata_i[15:0]; // RULE16 RULE17
          // transfer end clears on a written zero; a new end wins
          channel_control_register_r[c][dma_pkg::B_TE] <= te_set[c]
                                   | (channel_control_register_r[c][dma_pkg::B_TE] & reg_wdata_i[dma_pkg::B_TE]);
        end else if (te_set[c]) begin
          channel_control_register_r[c][dma_pkg::B_TE] <= 1'b1; // RULE19
        end
      end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        end_irq_o[c] <= 1'b0;
      end else if (ce_i) begin
        end_irq_o[c] <= (channel_control_register_r[c][dma_pkg::B_TE] | te_set[c]) & channel_control_register_r[c][dma_pkg::B_IE]; // RULE19
      end
    end
  end

  // operation register: flags set by hardware, cleared by a written zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opr_r <= dma_pkg::OPR_RST;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == dma_pkg::OFF_OPR) begin
        opr_r <= reg_wdata_i[15:0] & dma_pkg::OPR_WMASK; // RULE15
        opr_r[dma_pkg::B_NMI_STOP_FLAG] <= nmi_i
                               | (opr_r[dma_pkg::B_NMI_STOP_FLAG] & reg_wdata_i[dma_pkg::B_NMI_STOP_FLAG]); // RULE3
        opr_r[dma_pkg::B_AE] <= ae_set
                             | (opr_r[dma_pkg::B_AE] & reg_wdata_i[dma_pkg::B_AE]); // RULE20
      end else begin
        if (nmi_i) begin
          opr_r[dma_pkg::B_NMI_STOP_FLAG] <= 1'b1; // RULE3
        end
        if (ae_set) begin
          opr_r[dma_pkg::B_AE] <= 1'b1; // RULE20
        end
      end
    end
  end

  // register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (ch_hit(reg_addr_i)) begin
      case (reg_addr_i[3:0])
        dma_pkg::OFF_SAR:  rd_val = sar_r[reg_addr_i[5:4]];
        dma_pkg::OFF_DAR:  rd_val = dar_r[reg_addr_i[5:4]];
        dma_pkg::OFF_TCR:  rd_val = {16'h0000, tcr_r[reg_addr_i[5:4]]};
        dma_pkg::OFF_CHANNEL_CONTROL_REGISTER: rd_val = {16'h0000, channel_control_register_r[reg_addr_i[5:4]]};
        default:           rd_val = 32'h0000_0000;
      endcase
    end else if (reg_addr_i == dma_pkg::OFF_OPR) begin
      rd_val = {16'h0000, opr_r};
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_val : 32'h0000_0000;
    end
  end

  // bus sequencer: request, read, write, release
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r     <= dma_pkg::ST_IDLE;
      cur_r       <= 2'd0;
      rd_first_r  <= 1'b0;
      bus_req_o   <= 1'b0;
      mem_addr_o  <= 32'h0000_0000;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_word_o  <= 1'b0;
      mem_wdata_o <= '0;
      xfer_ack_o  <= '0;
    end else if (ce_i) begin
      rd_first_r <= 1'b0;
      case (state_r)
        dma_pkg::ST_IDLE: begin
          if (win[2]) begin
            cur_r     <= win[1:0]; // RULE15
            bus_req_o <= 1'b1;
            state_r   <= dma_pkg::ST_REQ;
          end
        end
        dma_pkg::ST_REQ: begin
          if (stop || !channel_control_register_r[cur_r][dma_pkg::B_DE]) begin
            state_r <= dma_pkg::ST_REL; // RULE4
          end else if (bus_grant_i) begin
            if (mis) begin
              state_r <= dma_pkg::ST_REL; // RULE20
            end else begin
              mem_addr_o <= sar_r[cur_r];
              mem_word_o <= cur_word;
              mem_rd_o   <= 1'b1;
              rd_first_r <= 1'b1;
              state_r    <= dma_pkg::ST_RD;
            end
          end
        end
        dma_pkg::ST_RD: begin
          if (mem_ready_i) begin
            mem_rd_o <= 1'b0;
            if (stop) begin
              state_r <= dma_pkg::ST_REL; // RULE4
            end else begin
              // acknowledge only with the write; a held level may resample first
              mem_addr_o         <= dar_r[cur_r];
              mem_wdata_o        <= mem_rdata_i;
              mem_wr_o           <= 1'b1;
              xfer_ack_o[cur_r]  <= 1'b1; // RULE11
              state_r            <= dma_pkg::ST_WR;
            end
          end
        end
        dma_pkg::ST_WR: begin
          if (done) begin
            mem_wr_o   <= 1'b0;
            xfer_ack_o <= '0;
            if (cur_burst && !stop && !last_unit && channel_control_register_r[cur_r][dma_pkg::B_DE]) begin
              // burst keeps the bus; the cpu waits until the count runs out
              mem_addr_o <= step(sar_r[cur_r], channel_control_register_r[cur_r][dma_pkg::SM_LSB +: 2], cur_word); // RULE5
              mem_rd_o   <= 1'b1;
              rd_first_r <= 1'b1;
              state_r    <= dma_pkg::ST_RD;
            end else begin
              state_r <= dma_pkg::ST_REL; // RULE6
            end
          end
        end
        dma_pkg::ST_REL: begin
          // one idle cycle with the request low gives the cpu its turn
          bus_req_o <= 1'b0; // RULE4 RULE6
          mem_rd_o  <= 1'b0;
          mem_wr_o  <= 1'b0;
          state_r   <= dma_pkg::ST_IDLE;
        end
        default: begin
          bus_req_o <= 1'b0;
          state_r   <= dma_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : dma_engine
`default_nettype wire

// file: rtl/dma_pkg.sv
// shared constants for the four-channel dma engine
package dma_pkg;
  localparam int NCH = 4;
  localparam int MDW = 16;

  // register byte offsets: channel n sits at n * CH_STRIDE
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_SPAN   = 8'h40;
  localparam logic [3:0] OFF_SAR   = 4'h0;
  localparam logic [3:0] OFF_DAR   = 4'h4;
  localparam logic [3:0] OFF_TCR   = 4'h8;
  localparam logic [3:0] OFF_CHANNEL_CONTROL_REGISTER  = 4'hc;
  localparam logic [7:0] OFF_OPR   = 8'h40;

  // channel control fields
  localparam int B_DE   = 0;
  localparam int B_TE   = 1;
  localparam int B_IE   = 2;
  localparam int B_TS   = 3;
  localparam int B_TM   = 4;
  localparam int B_DS   = 5;
  localparam int RS_LSB = 8;
  localparam int SM_LSB = 12;
  localparam int DM_LSB = 14;

  // operation register fields
  localparam int B_DME  = 0;
  localparam int B_NMI_STOP_FLAG = 1;
  localparam int B_AE   = 2;
  localparam int PR_LSB = 8;
  localparam logic [15:0] OPR_WMASK = 16'h0301;

  // reset values
  localparam logic [15:0] CHANNEL_CONTROL_REGISTER_RST = 16'h0000;
  localparam logic [15:0] OPR_RST  = 16'h0000;
  localparam logic [15:0] TCR_RST  = 16'h0000;
  localparam logic [31:0] ADR_RST  = 32'h0000_0000;

  // encodings
  localparam logic [3:0] RS_PIN = 4'h0;
  localparam logic [1:0] AM_FIX = 2'b00;
  localparam logic [1:0] AM_INC = 2'b01;
  localparam logic [1:0] AM_DEC = 2'b10;

  // fixed priority, first entry highest
  localparam logic [1:0] PRIO [NCH] = '{2'd0, 2'd3, 2'd2, 2'd1};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b011,
    ST_REL  = 3'b100
  } st_e;
endpackage : dma_pkg

// file: rtl/dma_req_if.sv
// request sampling signals between engine and sampler
`timescale 1ns/1ps
`default_nettype none
interface dma_req_if #(parameter int NCH = 4);
  logic           ce;
  logic [NCH-1:0] lvl_n;
  logic [NCH-1:0] edge_mode;
  logic [NCH-1:0] samp;
  logic [NCH-1:0] taken;
  logic [NCH-1:0] pend;
  modport ctl (output ce, lvl_n, edge_mode, samp, taken, input pend);
  modport smp (input ce, lvl_n, edge_mode, samp, taken, output pend);
endinterface : dma_req_if
`default_nettype wire

// file: rtl/dma_req_sampler.sv
// per-channel request detection, edge or level
`timescale 1ns/1ps
`default_nettype none
module dma_req_sampler #(
  parameter int NCH = 4
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // engine side
  dma_req_if.smp    rq
);
  logic [NCH-1:0] prev_r;
  logic [NCH-1:0] pend_r;

  assign rq.pend = pend_r;

  for (genvar c = 0; c < NCH; c++) begin : g_smp
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        prev_r[c] <= 1'b1;
        pend_r[c] <= 1'b0;
      end else if (rq.ce) begin
        prev_r[c] <= rq.lvl_n[c];
        if (rq.edge_mode[c]) begin
          // new edge wins over the take in the same cycle
          pend_r[c] <= (prev_r[c] & ~rq.lvl_n[c]) | (pend_r[c] & ~rq.taken[c]); // RULE13
        end else if (rq.samp[c]) begin
          pend_r[c] <= ~rq.lvl_n[c]; // RULE10
        end else if (rq.taken[c]) begin
          pend_r[c] <= 1'b0;
        end
      end
    end
  end
endmodule : dma_req_sampler
`default_nettype wire

// file: tb/dma_engine_sva.sv
// port assertions for the dma engine
`timescale 1ns/1ps
`default_nettype none
module dma_engine_sva #(
  parameter int NCH = 4,
  parameter int MDW = 16
) (
  // clock, reset, enable
  input wire logic           clk_sys_i, sys_rst_i, ce_i,
  // register port
  input wire logic [7:0]     reg_addr_i,
  input wire logic [31:0]    reg_wdata_i, reg_rdata_o,
  input wire logic           reg_wr_i, reg_rd_i, nmi_i,
  // requests
  input wire logic [NCH-1:0] xfer_req_n_i, req_pin_sel_i, xfer_ack_o, end_irq_o,
  input wire logic [15:0]    periph_req_i,
  // system bus
  input wire logic           bus_req_o, bus_grant_i, mem_rd_o, mem_wr_o, mem_word_o, mem_ready_i,
  input wire logic [31:0]    mem_addr_o,
  input wire logic [MDW-1:0] mem_wdata_o, mem_rdata_i
);
  logic [NCH-1:0] burst_r;
  logic           nmi_stop_flag_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // mode shadow, so release checks know which channels may keep the bus
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    if (sys_rst_i) burst_r <= '0;
    else if (reg_wr_i && reg_addr_i < dma_pkg::CH_SPAN && reg_addr_i[3:0] == dma_pkg::OFF_CHANNEL_CONTROL_REGISTER)
      burst_r[reg_addr_i[5:4]] <= reg_wdata_i[dma_pkg::B_TM];
  // set wins over a clearing write
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    if (sys_rst_i) nmi_stop_flag_r <= 1'b0;
    else if (nmi_i) nmi_stop_flag_r <= 1'b1;
    else if (reg_wr_i && reg_addr_i == dma_pkg::OFF_OPR && !reg_wdata_i[dma_pkg::B_NMI_STOP_FLAG]) nmi_stop_flag_r <= 1'b0;

  property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_nmi_stop_flag_read; reg_rd_i && reg_addr_i == dma_pkg::OFF_OPR && nmi_stop_flag_r |=> reg_rdata_o[1]; endproperty
  a_nmi_stop_flag_read: assert property (p_nmi_stop_flag_read) else $error("nmi flag not set");
  property p_nmi_release; nmi_i |-> ##[0:12] !bus_req_o; endproperty
  a_nmi_release: assert property (p_nmi_release) else $error("bus kept after nmi");
  property p_nmi_hold; nmi_stop_flag_r && $past(nmi_stop_flag_r) |-> !$rose(bus_req_o); endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("bus requested while stopped");
  property p_steal_release; $fell(|xfer_ack_o) && !(|($past(xfer_ack_o) & burst_r)) |-> ##1 !bus_req_o; endproperty
  a_steal_release: assert property (p_steal_release) else $error("steal unit kept bus");
  property p_ack_after_rd; $rose(|xfer_ack_o) |-> $past(mem_rd_o) && mem_wr_o; endproperty
  a_ack_after_rd: assert property (p_ack_after_rd) else $error("ack not on write after read");
  property p_rd_after_grant; $rose(mem_rd_o) |-> $past(bus_req_o && bus_grant_i); endproperty
  a_rd_after_grant: assert property (p_rd_after_grant) else $error("read without grant");
  property p_access_excl; mem_rd_o || mem_wr_o |-> bus_req_o && !(mem_rd_o && mem_wr_o); endproperty
  a_access_excl: assert property (p_access_excl) else $error("access without bus");
  property p_irq_after_unit; $rose(|end_irq_o) |-> $past(|xfer_ack_o) || $past(|xfer_ack_o, 2); endproperty
  a_irq_after_unit: assert property (p_irq_after_unit) else $error("end irq without unit");
endmodule : dma_engine_sva
bind dma_engine dma_engine_sva #(.NCH(NCH), .MDW(MDW)) u_sva (.*);
`default_nettype wire

// file: tb/dma_far_side.sv
// far-side model: bus arbiter and byte memory with optional wait states
`timescale 1ns/1ps
`default_nettype none
module dma_far_side (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // engine bus
  input  wire logic        want_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        word_i,
  input  wire logic        slow_i,
  // answers
  output logic             grant_o,
  output logic      [15:0] rdata_o,
  output logic             ready_o
);
  logic [7:0]  mem [256];
  logic [1:0]  wait_r;
  logic [15:0] val;
  // arbiter never holds the bus back, overlapped access stays off
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    if (sys_rst_i) grant_o <= 1'b0;
    else grant_o <= want_i;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    if (sys_rst_i) wait_r <= 2'd0;
    else if (ready_o || !(rd_i || wr_i)) wait_r <= 2'd0;
    else wait_r <= wait_r + 2'd1;
  assign ready_o = (rd_i || wr_i) && (wait_r >= (slow_i ? 2'd2 : 2'd0));
  assign val     = word_i ? {mem[addr_i[7:0]], mem[addr_i[7:0] | 8'h01]} : {2{mem[addr_i[7:0]]}};
  // outside the ready cycle show the inverse, so stale data never matches
  assign rdata_o = (ready_o && rd_i) ? val : ~val;
endmodule : dma_far_side
`default_nettype wire

// file: tb/dma_engine_bench.sv
// bench: registers, steal and burst copies, pin sampling, nmi stop
`timescale 1ns/1ps
`default_nettype none
module dma_engine_bench;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, nmi_i = 1'b0;
  logic slow_i = 1'b0, bus_req_o, bus_grant_i, mem_rd_o, mem_wr_o, mem_word_o, mem_ready_i, rd_pend = 1'b0, req_d = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, mem_addr_o, lf = 32'd83289;
  // pins start high, so switching them to request function raises no edge
  logic [3:0]  xfer_req_n_i = 4'hf, req_pin_sel_i = 4'hf, xfer_ack_o, end_irq_o;
  logic [15:0] periph_req_i = 16'h0, mem_wdata_o, mem_rdata_i;
  logic [28:0] e;
  logic [31:0] rq [$];
  logic [28:0] wq [$];
  int fail_count = 0, checks_done = 0, units = 0, drops = 0, u0, d0;

  dma_engine dut (.*);
  dma_far_side far (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .want_i(bus_req_o), .addr_i(mem_addr_o),
    .rd_i(mem_rd_o), .wr_i(mem_wr_o), .word_i(mem_word_o), .slow_i(slow_i), .grant_o(bus_grant_i),
    .rdata_o(mem_rdata_i), .ready_o(mem_ready_i));

  always #4 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] x, g);
    checks_done++;
    if (g !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      fail_count++;
    end
  endtask : chk
  // every access is a full 32-bit word
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a; rq.push_back(x);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask : rd
  task automatic exp(input int ch, n, input logic [7:0] sa, da, input int si, di, input logic wd);
    logic [7:0] a;
    for (int i = 0; i < n; i++) begin
      a = sa + 8'(i * si);
      wq.push_back({wd, 4'(1 << ch), da + 8'(i * di), wd ? {far.mem[a], far.mem[a | 8'h01]} : {2{far.mem[a]}}});
    end
  endtask : exp
  task automatic wait_units(input int n);
    for (int k = 0; k < 400 && units < n; k++) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
  endtask : wait_units
  // peripheral drops its request once the engine asks for the bus
  task automatic run_src(input int src, n);
    int b;
    b = units;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk_sys_i);
      periph_req_i[src] <= 1'b1;
      for (int k = 0; k < 50 && !bus_req_o; k++) @(posedge clk_sys_i);
      periph_req_i[src] <= 1'b0;
      wait_units(b + i);
    end
  endtask : run_src
  task automatic wait_ack(input int ch);
    for (int k = 0; k < 100 && !xfer_ack_o[ch]; k++) @(posedge clk_sys_i);
  endtask : wait_ack

  // result watcher: read data and bus writes against the oldest note
  always @(posedge clk_sys_i) begin
    rd_pend <= reg_rd_i;
    req_d <= bus_req_o;
    if (req_d && !bus_req_o) drops++;
    if (rd_pend) chk("reg_rdata_o", rq.pop_front(), reg_rdata_o);
    if (mem_wr_o && mem_ready_i) begin
      e = wq.pop_front();
      units++;
      chk("mem_addr_o", {24'h0, e[23:16]}, mem_addr_o);
      chk("mem_wdata_o", {16'h0, e[15:0] & (e[28] ? 16'hffff : 16'h00ff)}, {16'h0, mem_wdata_o & (e[28] ? 16'hffff : 16'h00ff)});
      chk("xfer_ack_o", {28'h0, e[27:24]}, {28'h0, xfer_ack_o});
      chk("mem_word_o", {31'h0, e[28]}, {31'h0, mem_word_o});
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      lf = lfsr_next(lf);
      far.mem[i] = lf[7:0];
    end
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      rd(8'(c * 16 + 8), 32'h0);
      rd(8'(c * 16 + 12), 32'h0);
    end
    rd(8'h40, 32'h0);
    wr(8'h44, 32'hffff);
    rd(8'h44, 32'h0);
    rd(8'h0d, 32'h0);
    // timer-paced byte copy on channel 3, cycle steal
    exp(3, 8, 8'h10, 8'h80, 1, 0, 1'b0);
    wr(8'h38, 32'h0008);
    wr(8'h30, 32'h10);
    wr(8'h34, 32'h80);
    wr(8'h3c, 32'h1805);
    wr(8'h40, 32'h0001);
    rd(8'h40, 32'h0001);
    rd(8'h3c, 32'h1805);
    d0 = drops;
    run_src(8, 8);
    chk("bus releases", 32'h8, 32'(drops - d0));
    chk("end_irq_o", 32'h8, {28'h0, end_irq_o});
    rd(8'h3c, 32'h1807);
    rd(8'h38, 32'h0);
    rd(8'h30, 32'h18);
    // serial receive copy, slow far side; enable cleared before the source changes
    wr(8'h3c, 32'h0);
    // interrupt level is registered from the old flag, so it drops one cycle late
    repeat (2) @(posedge clk_sys_i);
    chk("end_irq_o", 32'h0, {28'h0, end_irq_o});
    slow_i <= 1'b1;
    exp(3, 64, 8'h20, 8'h90, 0, 1, 1'b0);
    wr(8'h38, 32'h0040);
    wr(8'h30, 32'h20);
    wr(8'h34, 32'h90);
    wr(8'h3c, 32'h4405);
    run_src(4, 64);
    slow_i <= 1'b0;
    rd(8'h34, 32'hd0);
    rd(8'h3c, 32'h4407);
    // burst words on channel 0; a low pin switched in counts as an edge
    exp(0, 4, 8'h40, 8'ha0, 2, 2, 1'b1);
    req_pin_sel_i[0] <= 1'b0;
    xfer_req_n_i[0] <= 1'b0;
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h40);
    wr(8'h04, 32'ha0);
    wr(8'h0c, 32'h5039);
    d0 = drops;
    u0 = units;
    req_pin_sel_i[0] <= 1'b1;
    wait_units(u0 + 4);
    chk("bus releases", 32'h1, 32'(drops - d0));
    rd(8'h0c, 32'h503b);
    // level pin held until the first acknowledge gives one extra unit
    exp(1, 2, 8'h60, 8'hb0, 1, 1, 1'b0);
    wr(8'h18, 32'h4);
    wr(8'h10, 32'h60);
    wr(8'h14, 32'hb0);
    wr(8'h1c, 32'h5001);
    u0 = units;
    xfer_req_n_i[1] <= 1'b0;
    wait_ack(1);
    xfer_req_n_i[1] <= 1'b1;
    wait_units(u0 + 2);
    rd(8'h18, 32'h2);
    // nmi while idle, then during a transfer
    nmi_i <= 1'b1;
    @(posedge clk_sys_i);
    nmi_i <= 1'b0;
    rd(8'h40, 32'h3);
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h1);
    exp(2, 16, 8'h00, 8'hc0, 1, 1, 1'b0);
    wr(8'h28, 32'h10);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'hc0);
    wr(8'h2c, 32'h5005);
    u0 = units;
    xfer_req_n_i[2] <= 1'b0;
    wait_ack(2);
    nmi_i <= 1'b1;
    @(posedge clk_sys_i);
    nmi_i <= 1'b0;
    wait_units(u0 + 2);
    wq.delete();
    chk("units before stop", 32'h1, 32'(units - u0));
    chk("end_irq_o", 32'h0, {28'h0, end_irq_o & 4'h4});
    rd(8'h2c, 32'h5005);
    rd(8'h40, 32'h3);
    xfer_req_n_i[2] <= 1'b1;
    wr(8'h40, 32'h1);
    repeat (4) @(posedge clk_sys_i);
    end_of_test();
  end
endmodule : dma_engine_bench
`default_nettype wire
